// File: verilog/dmch_pkg.sv
/*
 package for the display mode command handler: command codes, register
 addresses, reset values. assumes a decoded host port delivering
 16-bit addresses with 16-bit data, or single-byte codes with data bytes.
*/
// Function
// - inversion-entry command inverts output pixels; memory and other status unchanged.
// - inversion off after every reset; inversion-exit command restores normal output.
// - all-black command blanks panel black; normal or partial display command leaves it.
// - all-white command drives panel white; normal or partial display command leaves it; the code shows black instead while display is off.
// - gamma byte one-hot 01h/02h/04h/08h; others ignored; default 01h.
// - display-off command stops memory output and shows a blank page.
// - display-on command resumes memory output; display defaults off after resets.
// - column command bytes one and two form the start column, high first.
// - column command bytes three and four form the end column, high first.
// - every mode command accepted in all power and display states, sleep in too.
package dmch_pkg;

    // ------------------------------------------------------------
    // single-byte command codes
    // ------------------------------------------------------------
    localparam logic [7:0] INV_EXIT_CODE = 8'h20;
    localparam logic [7:0] INV_ENTER_CODE = 8'h21;
    localparam logic [7:0] ALL_BLACK_CODE = 8'h22;
    localparam logic [7:0] ALL_WHITE_CODE = 8'h23;
    localparam logic [7:0] GAMMA_CODE = 8'h26;
    localparam logic [7:0] BLANK_CODE = 8'h28;
    localparam logic [7:0] RESUME_CODE = 8'h29;
    localparam logic [7:0] COLUMN_CODE = 8'h2a;
    localparam logic [7:0] NORMAL_DISP_CODE = 8'h13;
    localparam logic [7:0] PARTIAL_DISP_CODE = 8'h12;

    // ------------------------------------------------------------
    // 16-bit register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] GAMMA_CURVE_SELECT_ADDR = 16'h2600;
    localparam logic [15:0] COLUMN_START_HIGH_ADDR = 16'h2a00;
    localparam logic [15:0] COLUMN_START_LOW_ADDR = 16'h2a01;
    localparam logic [15:0] COLUMN_END_HIGH_ADDR = 16'h2a02;
    localparam logic [15:0] COLUMN_END_LOW_ADDR = 16'h2a03;

    // ------------------------------------------------------------
    // reset values and field widths
    // ------------------------------------------------------------
    localparam logic [7:0] GAMMA_RESET = 8'h01;
    localparam logic [15:0] COLUMN_START_RESET = 16'h0000;
    localparam logic [15:0] COLUMN_END_RESET = 16'h0000;
    localparam int COL_W = 16;
    localparam int PARAM_COUNT = 4;

    typedef enum logic [1:0]
    {
        DMCH_FILL_NONE = 2'b00,
        DMCH_FILL_BLACK = 2'b01,
        DMCH_FILL_WHITE = 2'b10
    } dmch_fill_type;

endpackage

// File: verilog/dmch_gamma_filter.sv
/*
 gamma selection holder: keeps the current curve byte, accepts only
 one-hot low-nibble codes. assumes a one-cycle write strobe.
*/
`timescale 1ns/10ps
module dmch_gamma_filter
    import dmch_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write side
    input wire logic wr_en,
    input wire logic [7:0] wr_data,
    // current choice
    output logic [7:0] gamma_choice
);

    logic [7:0] gamma_q;
    logic [7:0] gamma_d;

    function automatic logic valid_code(input logic [7:0] v);
        valid_code = (v == 8'h01) || (v == 8'h02) || (v == 8'h04) || (v == 8'h08);
    endfunction

    // ------------------------------------------------------------
    // next value
    // ------------------------------------------------------------
    always_comb
    begin
        gamma_d = gamma_q;
        if (wr_en && valid_code(wr_data))
        begin
            gamma_d = wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            gamma_q <= GAMMA_RESET;
        end
        else
        begin
            gamma_q <= gamma_d;
        end
    end

    assign gamma_choice = gamma_q;

endmodule

// File: verilog/dmch_column_reg.sv
/*
 column window holder: assembles start and end columns from four
 byte writes, high byte first. assumes an index 0..3 per write.
*/
`timescale 1ns/10ps
module dmch_column_reg
    import dmch_pkg::*;
#(
    parameter int COLW = COL_W
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // byte writes
    input wire logic wr_en,
    input wire logic [1:0] wr_index,
    input wire logic [7:0] wr_data,
    // assembled window
    output logic [COLW-1:0] column_start,
    output logic [COLW-1:0] column_end,
    output logic window_update
);

    logic [COLW-1:0] start_q;
    logic [COLW-1:0] start_d;
    logic [COLW-1:0] end_q;
    logic [COLW-1:0] end_d;
    logic upd_q;
    logic upd_d;

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    always_comb
    begin
        start_d = start_q;
        end_d = end_q;
        upd_d = 1'b0;
        if (wr_en)
        begin
            case (wr_index)
                2'd0: start_d = {wr_data, start_q[7:0]};
                2'd1: start_d = {start_q[COLW-1:8], wr_data};
                2'd2: end_d = {wr_data, end_q[7:0]};
                2'd3:
                begin
                    end_d = {end_q[COLW-1:8], wr_data};
                    upd_d = 1'b1;
                end
                default: upd_d = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            start_q <= COLUMN_START_RESET;
            end_q <= COLUMN_END_RESET;
            upd_q <= 1'b0;
        end
        else
        begin
            start_q <= start_d;
            end_q <= end_d;
            upd_q <= upd_d;
        end
    end

    assign column_start = start_q;
    assign column_end = end_q;
    assign window_update = upd_q;

endmodule

// File: verilog/dmch_top.sv
/*
 display mode command handler top: decodes host commands into inversion,
 fill, blanking, gamma and column window state. assumes the host port
 front end presents one write per cycle as a strobe with either a
 single-byte code (serial link, cmd_strobe / param_strobe) or a 16-bit
 address with data (parallel ports, addr_strobe).
*/
`timescale 1ns/10ps
module dmch_top
    import dmch_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // software reset request, one cycle
    input wire logic soft_reset,
    // serial link: command byte and parameter byte strobes
    input wire logic cmd_strobe,
    input wire logic param_strobe,
    input wire logic [7:0] link_byte,
    // parallel ports: 16-bit address and data
    input wire logic addr_strobe,
    input wire logic [15:0] host_addr,
    input wire logic [15:0] host_data,
    // display state
    output logic inversion_on,
    output logic all_black,
    output logic all_white,
    output logic display_on,
    output logic [7:0] gamma_choice,
    output logic [COL_W-1:0] column_start,
    output logic [COL_W-1:0] column_end,
    output logic window_update,
    // pixel path
    input wire logic [23:0] mem_pixel,
    output logic [23:0] panel_pixel
);

    // ------------------------------------------------------------
    // reset release
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_s2_q;
    logic rstn_sync;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end

    assign rstn_sync = rst_s2_q;

    // ------------------------------------------------------------
    // parameter sequencer for serial commands
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        SEQ_IDLE = 3'b001,
        SEQ_GAMMA = 3'b010,
        SEQ_COLUMN = 3'b100
    } dmch_seq_type;

    dmch_seq_type seq_q;
    dmch_seq_type seq_d;
    logic [1:0] pidx_q;
    logic [1:0] pidx_d;

    // decoded write pulses
    logic do_enter;
    logic do_exit;
    logic do_black;
    logic do_white;
    logic do_normal;
    logic do_blank;
    logic do_resume;
    logic gamma_wr;
    logic [7:0] gamma_byte;
    logic col_wr;
    logic [1:0] col_idx;
    logic [7:0] col_byte;

    function automatic logic code_hit(input logic [7:0] c, input logic [7:0] ref_code);
        code_hit = (c == ref_code);
    endfunction

    // no power or sleep state gates decoding
    always_comb
    begin
        seq_d = seq_q;
        pidx_d = pidx_q;
        do_enter = 1'b0;
        do_exit = 1'b0;
        do_black = 1'b0;
        do_white = 1'b0;
        do_normal = 1'b0;
        do_blank = 1'b0;
        do_resume = 1'b0;
        gamma_wr = 1'b0;
        gamma_byte = 8'h00;
        col_wr = 1'b0;
        col_idx = 2'd0;
        col_byte = 8'h00;
        if (cmd_strobe)
        begin
            // a new code aborts any unfinished parameter list
            seq_d = SEQ_IDLE;
            pidx_d = 2'd0;
            do_enter = code_hit(link_byte, INV_ENTER_CODE);
            do_exit = code_hit(link_byte, INV_EXIT_CODE);
            do_black = code_hit(link_byte, ALL_BLACK_CODE);
            do_white = code_hit(link_byte, ALL_WHITE_CODE);
            do_normal = code_hit(link_byte, NORMAL_DISP_CODE)
                || code_hit(link_byte, PARTIAL_DISP_CODE);
            do_blank = code_hit(link_byte, BLANK_CODE);
            do_resume = code_hit(link_byte, RESUME_CODE);
            if (code_hit(link_byte, GAMMA_CODE))
            begin
                seq_d = SEQ_GAMMA;
            end
            // serial column command is one code then four bytes
            if (code_hit(link_byte, COLUMN_CODE))
            begin
                seq_d = SEQ_COLUMN;
            end
        end
        else if (param_strobe)
        begin
            case (seq_q)
                SEQ_GAMMA:
                begin
                    gamma_wr = 1'b1;
                    gamma_byte = link_byte;
                    seq_d = SEQ_IDLE;
                end
                SEQ_COLUMN:
                begin
                    col_wr = 1'b1;
                    col_idx = pidx_q;
                    col_byte = link_byte;
                    pidx_d = pidx_q + 2'd1;
                    if (pidx_q == 2'd3)
                    begin
                        seq_d = SEQ_IDLE;
                    end
                end
                SEQ_IDLE: seq_d = SEQ_IDLE;
                default:
                begin
                    seq_d = SEQ_IDLE;
                    pidx_d = 2'd0;
                end
            endcase
        end
        else if (addr_strobe)
        begin
            // 16-bit form: command code in the high address byte
            do_enter = host_addr == {INV_ENTER_CODE, 8'h00};
            do_exit = host_addr == {INV_EXIT_CODE, 8'h00};
            do_black = host_addr == {ALL_BLACK_CODE, 8'h00};
            do_white = host_addr == {ALL_WHITE_CODE, 8'h00};
            do_normal = (host_addr == {NORMAL_DISP_CODE, 8'h00})
                || (host_addr == {PARTIAL_DISP_CODE, 8'h00});
            do_blank = host_addr == {BLANK_CODE, 8'h00};
            do_resume = host_addr == {RESUME_CODE, 8'h00};
            // host keeps the upper byte zero; only the low byte is used
            if (host_addr == GAMMA_CURVE_SELECT_ADDR)
            begin
                gamma_wr = 1'b1;
                gamma_byte = host_data[7:0];
            end
            // four consecutive addresses load the window
            if ((host_addr >= COLUMN_START_HIGH_ADDR) && (host_addr <= COLUMN_END_LOW_ADDR))
            begin
                col_wr = 1'b1;
                col_idx = host_addr[1:0];
                col_byte = host_data[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn_sync)
    begin
        if (!rstn_sync)
        begin
            seq_q <= SEQ_IDLE;
            pidx_q <= 2'd0;
        end
        else
        begin
            seq_q <= soft_reset ? SEQ_IDLE : seq_d;
            pidx_q <= soft_reset ? 2'd0 : pidx_d;
        end
    end

    // ------------------------------------------------------------
    // display mode flags
    // ------------------------------------------------------------
    logic inv_q;
    logic inv_d;
    dmch_fill_type fill_q;
    dmch_fill_type fill_d;
    logic disp_q;
    logic disp_d;

    always_comb
    begin
        inv_d = inv_q;
        fill_d = fill_q;
        disp_d = disp_q;
        if (do_enter)
        begin
            inv_d = 1'b1;
        end
        if (do_exit)
        begin
            inv_d = 1'b0;
        end
        if (do_black)
        begin
            fill_d = DMCH_FILL_BLACK;
        end
        if (do_white)
        begin
            fill_d = DMCH_FILL_WHITE;
        end
        if (do_normal)
        begin
            fill_d = DMCH_FILL_NONE;
        end
        if (do_blank)
        begin
            disp_d = 1'b0;
        end
        if (do_resume)
        begin
            disp_d = 1'b1;
        end
        // repeats rewrite the same value, no glitch
        if (soft_reset)
        begin
            inv_d = 1'b0;
            fill_d = DMCH_FILL_NONE;
            disp_d = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn_sync)
    begin
        if (!rstn_sync)
        begin
            inv_q <= 1'b0;
            fill_q <= DMCH_FILL_NONE;
            disp_q <= 1'b0;
        end
        else
        begin
            inv_q <= inv_d;
            fill_q <= fill_d;
            disp_q <= disp_d;
        end
    end

    // ------------------------------------------------------------
    // parameter holders
    // ------------------------------------------------------------
    logic sub_rst_n;

    // soft reset clears modes and the serial sequencer; gamma and window keep last values
    assign sub_rst_n = rstn_sync;

    dmch_gamma_filter u_gamma
    (
        .clk(sys_clk),
        .rst_n(sub_rst_n),
        .wr_en(gamma_wr),
        .wr_data(gamma_byte),
        .gamma_choice(gamma_choice)
    );

    dmch_column_reg #(.COLW(COL_W)) u_column
    (
        .clk(sys_clk),
        .rst_n(sub_rst_n),
        .wr_en(col_wr),
        .wr_index(col_idx),
        .wr_data(col_byte),
        .column_start(column_start),
        .column_end(column_end),
        .window_update(window_update)
    );

    // ------------------------------------------------------------
    // pixel path, registered
    // ------------------------------------------------------------
    logic [23:0] pix_q;
    logic [23:0] pix_d;

    always_comb
    begin
        if (!disp_q)
        begin
            pix_d = 24'h000000;
        end
        else if (fill_q == DMCH_FILL_BLACK)
        begin
            pix_d = 24'h000000;
        end
        else if (fill_q == DMCH_FILL_WHITE)
        begin
            pix_d = 24'hffffff;
        end
        else
        begin
            pix_d = inv_q ? ~mem_pixel : mem_pixel;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn_sync)
    begin
        if (!rstn_sync)
        begin
            pix_q <= 24'h000000;
        end
        else
        begin
            pix_q <= pix_d;
        end
    end

    assign panel_pixel = pix_q;
    assign inversion_on = inv_q;
    assign all_black = (fill_q == DMCH_FILL_BLACK);
    assign all_white = (fill_q == DMCH_FILL_WHITE);
    assign display_on = disp_q;

endmodule

// File: testbench/dmch_top_properties.sv
/*
 port assertions for the display mode command handler.
 assumes one clock, bound onto dmch_top below.
*/
`timescale 1ns/10ps
module dmch_top_properties
    import dmch_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // host side
    input wire logic soft_reset,
    input wire logic cmd_strobe,
    input wire logic param_strobe,
    input wire logic [7:0] link_byte,
    input wire logic addr_strobe,
    input wire logic [15:0] host_addr,
    input wire logic [15:0] host_data,
    // display state
    input wire logic inversion_on,
    input wire logic all_black,
    input wire logic all_white,
    input wire logic display_on,
    input wire logic [7:0] gamma_choice,
    input wire logic [COL_W-1:0] column_start,
    input wire logic [COL_W-1:0] column_end,
    input wire logic window_update,
    // pixel path
    input wire logic [23:0] mem_pixel,
    input wire logic [23:0] panel_pixel
);
    // ----
    // decoded request
    // ----
    logic take;
    logic gw;
    logic [7:0] code;
    logic [23:0] pix_exp;
    assign take = !soft_reset && (cmd_strobe
        || (!param_strobe && addr_strobe && host_addr[7:0] == 8'h00));
    assign code = cmd_strobe ? link_byte : host_addr[15:8];
    // parallel form only; serial gamma needs the sequencer
    assign gw = !soft_reset && !cmd_strobe && !param_strobe && addr_strobe
        && host_addr == 16'h2600;
    assign pix_exp = (!display_on || all_black) ? 24'h000000
        : all_white ? 24'hffffff : inversion_on ? ~mem_pixel : mem_pixel;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    a_inv_enter: assert property (
        take && code == 8'h21 |=> inversion_on) else $error("inversion not entered");
    a_inv_exit: assert property (
        take && code == 8'h20 |=> !inversion_on) else $error("inversion not left");
    a_black_set: assert property (
        take && code == 8'h22 |=> all_black && !all_white) else $error("black fill missing");
    a_white_set: assert property (
        take && code == 8'h23 |=> all_white && !all_black) else $error("white fill missing");
    a_fill_leave: assert property (
        take && (code == 8'h12 || code == 8'h13) |=> !all_black && !all_white)
        else $error("fill not left");
    a_blank_out: assert property (
        take && code == 8'h28 |=> !display_on) else $error("output not blanked");
    a_resume_out: assert property (
        take && code == 8'h29 |=> display_on) else $error("output not resumed");
    a_gamma_load: assert property (
        gw && host_data[7:0] inside {8'h01, 8'h02, 8'h04, 8'h08}
        |=> gamma_choice == $past(host_data[7:0])) else $error("gamma not loaded");
    a_gamma_keep: assert property (
        gw && !(host_data[7:0] inside {8'h01, 8'h02, 8'h04, 8'h08})
        |=> $stable(gamma_choice)) else $error("bad gamma accepted");
    a_mode_hold: assert property (
        !cmd_strobe && !param_strobe && !addr_strobe && !soft_reset
        |=> $stable({inversion_on, all_black, all_white, display_on}))
        else $error("mode moved without command");
    a_pixel_path: assert property (
        rst_n |=> panel_pixel == $past(pix_exp)) else $error("panel pixel wrong");
    a_window_pulse: assert property (
        window_update |=> !window_update) else $error("window pulse too long");
    a_window_load: assert property (
        addr_strobe && !cmd_strobe && !param_strobe && host_addr == 16'h2a03
        |=> window_update && column_end[7:0] == $past(host_data[7:0]))
        else $error("end column low byte not loaded");
endmodule

bind dmch_top dmch_top_properties i_dmch_top_properties
(
    .sys_clk(sys_clk), .rst_n(rst_n), .soft_reset(soft_reset),
    .cmd_strobe(cmd_strobe), .param_strobe(param_strobe), .link_byte(link_byte),
    .addr_strobe(addr_strobe), .host_addr(host_addr), .host_data(host_data),
    .inversion_on(inversion_on), .all_black(all_black), .all_white(all_white),
    .display_on(display_on), .gamma_choice(gamma_choice), .column_start(column_start),
    .column_end(column_end), .window_update(window_update), .mem_pixel(mem_pixel),
    .panel_pixel(panel_pixel)
);

// File: testbench/dmch_host_model.sv
/*
 host processor model issuing commands and parameters.
 assumes one write per call, taken on the next rising edge.
*/
`timescale 1ns/10ps
module dmch_host_model
(
    // clock
    input wire logic sys_clk,
    // host port
    output logic cmd_strobe,
    output logic param_strobe,
    output logic [7:0] link_byte,
    output logic addr_strobe,
    output logic [15:0] host_addr,
    output logic [15:0] host_data
);
    initial
    begin
        {cmd_strobe, param_strobe, addr_strobe} = 3'b000;
        link_byte = 8'h00;
        host_addr = 16'h0000;
        host_data = 16'h0000;
    end

    // k: 0 serial code, 1 serial byte, 2 wide address write
    task automatic drive(input int k, input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        #1;
        cmd_strobe = (k == 0);
        param_strobe = (k == 1);
        addr_strobe = (k == 2);
        link_byte = d;
        host_addr = a;
        host_data = {8'h00, d};
        @(posedge sys_clk);
        #1;
        {cmd_strobe, param_strobe, addr_strobe} = 3'b000;
        // released lines must not look still valid
        link_byte = ~d;
        host_addr = ~a;
        host_data = ~host_data;
    endtask
endmodule

// File: testbench/dmch_top_test.sv
/*
 self-checking bench for the display mode command handler.
 assumes the host model drives the command port, bench drives the rest.
*/
`timescale 1ns/10ps
module dmch_top_test
    import dmch_pkg::*;
;
    logic sys_clk, rst_n, soft_reset, cmd_strobe, param_strobe, addr_strobe;
    logic inversion_on, all_black, all_white, display_on, window_update;
    logic [7:0] link_byte, gamma_choice;
    logic [15:0] host_addr, host_data, column_start, column_end;
    logic [23:0] mem_pixel, panel_pixel;
    int num_errors, cmp_count;
    // {inversion, black, white, display} after each code
    logic [7:0] codes [14] = '{8'h29, 8'h21, 8'h21, 8'h20, 8'h21, 8'h22, 8'h23,
        8'h13, 8'h22, 8'h12, 8'h2b, 8'h28, 8'h28, 8'h29};
    logic [3:0] modes [14] = '{4'h1, 4'h9, 4'h9, 4'h1, 4'h9, 4'hd, 4'hb,
        4'h9, 4'hd, 4'h9, 4'h9, 4'h8, 4'h8, 4'h9};
    logic [7:0] gvals [7] = '{8'h02, 8'h03, 8'h00, 8'h08, 8'h10, 8'h04, 8'h01};
    logic [7:0] gexp [7] = '{8'h02, 8'h02, 8'h02, 8'h08, 8'h08, 8'h04, 8'h01};

    always #10 sys_clk = ~sys_clk;

    dmch_host_model i_dmch_host_model
    (
        .sys_clk(sys_clk), .cmd_strobe(cmd_strobe), .param_strobe(param_strobe),
        .link_byte(link_byte), .addr_strobe(addr_strobe), .host_addr(host_addr),
        .host_data(host_data)
    );

    dmch_top i_dmch_top
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .soft_reset(soft_reset),
        .cmd_strobe(cmd_strobe), .param_strobe(param_strobe), .link_byte(link_byte),
        .addr_strobe(addr_strobe), .host_addr(host_addr), .host_data(host_data),
        .inversion_on(inversion_on), .all_black(all_black), .all_white(all_white),
        .display_on(display_on), .gamma_choice(gamma_choice), .column_start(column_start),
        .column_end(column_end), .window_update(window_update), .mem_pixel(mem_pixel),
        .panel_pixel(panel_pixel)
    );

    // ----
    // shared tasks
    // ----
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons=%0d mismatches=%0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // ----
    // scenarios
    // ----
    task automatic run_reset();
        rst_n = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        check({inversion_on, all_black, all_white, display_on}, 4'h0);
        check(gamma_choice, GAMMA_RESET);
        check({column_start, column_end}, 32'h0);
        check(panel_pixel, 24'h0);
        rst_n = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask

    task automatic run_modes();
        logic [23:0] px;
        for (int i = 0; i < 14; i++)
        begin
            // alternate serial code and wide address forms
            if (i % 2)
                i_dmch_host_model.drive(0, 16'h0000, codes[i]);
            else
                i_dmch_host_model.drive(2, {codes[i], 8'h00}, 8'h00);
            check({inversion_on, all_black, all_white, display_on}, modes[i]);
            @(posedge sys_clk);
            #1;
            px = (!modes[i][0] || modes[i][2]) ? 24'h0 : modes[i][1] ? 24'hffffff
                : modes[i][3] ? ~mem_pixel : mem_pixel;
            check(panel_pixel, px);
        end
    endtask

    task automatic run_gamma();
        for (int i = 0; i < 7; i++)
        begin
            i_dmch_host_model.drive(2, 16'h2600, gvals[i]);
            check(gamma_choice, gexp[i]);
        end
        i_dmch_host_model.drive(0, 16'h0000, 8'h26);
        i_dmch_host_model.drive(1, 16'h0000, 8'h04);
        check(gamma_choice, 8'h04);
    endtask

    task automatic run_column();
        int n;
        i_dmch_host_model.drive(0, 16'h0000, 8'h2a);
        for (int i = 1; i < 5; i++)
            i_dmch_host_model.drive(1, 16'h0000, 8'(i));
        n = 0;
        while (window_update !== 1'b1 && n < 4)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        if (window_update !== 1'b1)
        begin
            num_errors++;
            give_verdict();
        end
        check({column_start, column_end}, 32'h01020304);
        @(posedge sys_clk);
        #1;
        check(window_update, 1'b0);
        // bytes land as they arrive; a new code drops only the rest
        i_dmch_host_model.drive(0, 16'h0000, 8'h2a);
        i_dmch_host_model.drive(1, 16'h0000, 8'haa);
        i_dmch_host_model.drive(0, 16'h0000, 8'h29);
        i_dmch_host_model.drive(1, 16'h0000, 8'hbb);
        check({column_start, column_end}, 32'haa020304);
        i_dmch_host_model.drive(2, 16'h2a00, 8'hff);
        i_dmch_host_model.drive(2, 16'h2a01, 8'hee);
        i_dmch_host_model.drive(2, 16'h2a02, 8'h00);
        i_dmch_host_model.drive(2, 16'h2a03, 8'h11);
        @(posedge sys_clk);
        #1;
        check({column_start, column_end}, 32'hffee0011);
    endtask

    task automatic run_soft();
        i_dmch_host_model.drive(2, 16'h2300, 8'h00);
        i_dmch_host_model.drive(2, 16'h2600, 8'h08);
        soft_reset = 1'b1;
        @(posedge sys_clk);
        #1;
        soft_reset = 1'b0;
        check({inversion_on, all_black, all_white, display_on}, 4'h0);
        check(gamma_choice, 8'h08);
    endtask

    initial
    begin
        sys_clk = 1'b0;
        soft_reset = 1'b0;
        mem_pixel = 24'h5a3c96;
        num_errors = 0;
        cmp_count = 0;
        run_reset();
        run_modes();
        run_gamma();
        run_column();
        run_soft();
        run_reset();
        give_verdict();
    end
endmodule
